// File: core/fst_pkg.sv
/*
 * shared constants and the check-bit generator for the flash ecc link.
 * assumes one clock, word addressing and 64-bit data words.
 */
package fst_pkg;

    // ------------------------------------------------------------
    // widths and map
    // ------------------------------------------------------------
    localparam int DATA_W = 64; // data word width
    localparam int CHK_W = 8; // check bits per word
    localparam int HAM_W = 7; // hamming part of the check bits
    localparam int CW_W = 72; // code word width
    localparam int ADDR_W = 10; // word address, power-of-two space
    localparam int FLASH_WORDS = 768; // words backed by flash
    localparam logic [ADDR_W-1:0] FLASH_LAST = 10'h2FF; // last backed word
    localparam logic [1:0] RESP_OKAY = 2'h0; // bus answer: fine
    localparam logic [1:0] RESP_SLVERR = 2'h2; // bus answer: error

    // ------------------------------------------------------------
    // check bits: hamming over positions 1..71, data at non-powers
    // ------------------------------------------------------------
    function automatic logic [CHK_W-1:0] fst_check_bits(
        input logic [DATA_W-1:0] d
    );
        logic [HAM_W-1:0] s;
        int j;
        s = '0;
        j = 0;
        for (int p = 1; p < CW_W; p++) begin
            if ((p & (p - 1)) != 0) begin
                if (d[j]) begin
                    s = s ^ 7'(p);
                end
                j++;
            end
        end
        // overall parity bit makes double errors visible
        return {(^d) ^ (^s), s};
    endfunction : fst_check_bits

endpackage : fst_pkg

// File: core/fst_link_if.sv
/*
 * link between the flash interface and the processor end.
 * assumes both ends run on clk and are reset by reset_n.
 */
`timescale 1ns/100ps
interface fst_link_if
    import fst_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic reset_n // async reset, active low
);
    // system bus port: processor is master
    logic axi_req; // request pulse
    logic axi_we; // write when high
    logic [ADDR_W-1:0] axi_addr; // word address
    logic [DATA_W-1:0] axi_wdata; // write data
    logic axi_rvalid; // answer pulse
    logic [DATA_W-1:0] axi_rdata; // corrected read data
    logic [1:0] axi_resp; // answer code
    // tightly coupled port
    logic tcm_req; // request pulse
    logic tcm_we; // write when high
    logic [ADDR_W-1:0] tcm_addr; // word address
    logic [DATA_W-1:0] tcm_wdata; // write data
    logic tcm_rvalid; // answer pulse
    logic [DATA_W-1:0] tcm_rdata; // raw stored data
    logic [CHK_W-1:0] tcm_rcheck; // raw stored check bits
    logic tcm_ext_err; // external error, with the answer

    modport dev (
        input clk, reset_n,
        input axi_req, axi_we, axi_addr, axi_wdata,
        output axi_rvalid, axi_rdata, axi_resp,
        input tcm_req, tcm_we, tcm_addr, tcm_wdata,
        output tcm_rvalid, tcm_rdata, tcm_rcheck, tcm_ext_err
    );
    modport cpu (
        input clk, reset_n,
        output axi_req, axi_we, axi_addr, axi_wdata,
        input axi_rvalid, axi_rdata, axi_resp,
        output tcm_req, tcm_we, tcm_addr, tcm_wdata,
        input tcm_rvalid, tcm_rdata, tcm_rcheck, tcm_ext_err
    );
endinterface : fst_link_if

// File: core/fst_secded_dec.sv
/*
 * combinational sec-ded syndrome check and single-bit correction.
 * assumes check bits made by fst_check_bits.
 */
`timescale 1ns/100ps
module fst_secded_dec
    import fst_pkg::*;
(
    input wire logic [DATA_W-1:0] data, // stored data
    input wire logic [CHK_W-1:0] check, // stored check bits
    output logic [DATA_W-1:0] data_fixed, // corrected data
    output logic err_single, // one bit wrong, corrected
    output logic err_double // two or more wrong
);
    // ------------------------------------------------------------
    // syndrome and classification
    // ------------------------------------------------------------
    logic [CHK_W-1:0] recomp; // check bits of data as read
    logic [HAM_W-1:0] syn; // hamming syndrome
    logic par; // overall parity of the code word

    always_comb begin
        int j;
        j = 0;
        recomp = fst_check_bits(data);
        syn = recomp[HAM_W-1:0] ^ check[HAM_W-1:0];
        par = (^data) ^ (^check);
        // exactly one of three outcomes
        // a syndrome past the last position means three or more wrong
        err_single = par && (syn < 7'(CW_W));
        err_double = (!par && (syn != '0)) || (par && (syn >= 7'(CW_W)));
        data_fixed = data;
        // flip only a data bit; double errors stay untouched
        for (int p = 1; p < CW_W; p++) begin
            if ((p & (p - 1)) != 0) begin
                if (par && (syn == 7'(p))) begin
                    data_fixed[j] = !data[j];
                end
                j++;
            end
        end
    end
endmodule : fst_secded_dec

// File: core/fst_flash_if.sv
/*
 * flash interface end: flash array, ecc on the system bus port,
 * raw data and external error on the tightly coupled port.
 * assumes the processor end on the other side of fst_link_if and
 * a program/erase busy level from logic on the same clock.
 */
`timescale 1ns/100ps

// Contract
// - flash interface does sec-ded on bus port
// - encode on write, syndrome on read
// - read classed none, single or double
// - correct single errors, only flag double
// - eight check bits per 64-bit word
// - external error on any coupled-port write
// - external error on unbacked reserved addresses
// - external error during program or erase
// - processor aborts or slverr on error
// - processor writes back corrected tcm data
// - correction off: single error aborts
// - separate error and check enables
// - software clears external error enable
// - error disabled: use corrected data silently
module fst_flash_if
    import fst_pkg::*;
(
    fst_link_if.dev link, // link to the processor end
    input wire logic pe_busy, // program or erase running
    input wire logic flip_valid, // fault injection strobe
    input wire logic [ADDR_W-1:0] flip_addr, // word to disturb
    input wire logic [CW_W-1:0] flip_mask, // bits to invert
    output logic axi_single, // pulse: bus read corrected
    output logic axi_double // pulse: bus read uncorrectable
);

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    // each word holds check bits above the data
    logic [CW_W-1:0] mem [FLASH_WORDS];
    logic [CW_W-1:0] axi_word; // word at the bus address
    logic [CW_W-1:0] tcm_word; // word at the coupled address
    logic axi_hit; // bus address is backed
    logic tcm_hit; // coupled address is backed
    logic [DATA_W-1:0] axi_fixed; // corrected bus read data
    logic axi_sgl; // single error seen
    logic axi_dbl; // double error seen
    logic [CHK_W-1:0] wr_check; // check bits of write data

    // backed range is below the power-of-two space limit
    assign axi_hit = link.axi_addr <= FLASH_LAST;
    assign tcm_hit = link.tcm_addr <= FLASH_LAST;

    // ------------------------------------------------------------
    // array read and check-bit generation
    // ------------------------------------------------------------
    // unbacked reads see zero, never index past the array
    always_comb begin
        axi_word = '0;
        tcm_word = '0;
        if (axi_hit) begin
            axi_word = mem[link.axi_addr];
        end
        if (tcm_hit) begin
            tcm_word = mem[link.tcm_addr];
        end
    end

    // encode every bus write
    always_comb begin
        wr_check = fst_check_bits(link.axi_wdata);
    end

    // syndrome check of the bus read word, on every read
    // same decoder as the processor end uses on raw words
    fst_secded_dec u_axi_dec (
        .data(axi_word[DATA_W-1:0]),
        .check(axi_word[CW_W-1:DATA_W]),
        .data_fixed(axi_fixed),
        .err_single(axi_sgl),
        .err_double(axi_dbl)
    );

    // ------------------------------------------------------------
    // array write: bus programs, injection disturbs
    // ------------------------------------------------------------
    // bus write wins over an injection in the same cycle
    always_ff @(posedge link.clk) begin
        if (link.axi_req && link.axi_we && axi_hit && !pe_busy) begin
            mem[link.axi_addr] <= {wr_check, link.axi_wdata};
        // injected faults stand in for stressed flash cells
        end else if (flip_valid && (flip_addr <= FLASH_LAST)) begin
            mem[flip_addr] <= mem[flip_addr] ^ flip_mask;
        end
    end

    // ------------------------------------------------------------
    // system bus port answer
    // ------------------------------------------------------------
    logic axi_rvalid_reg; // answer pulse
    logic [DATA_W-1:0] axi_rdata_reg; // answer data
    logic [1:0] axi_resp_reg; // answer code
    logic axi_single_reg; // corrected flag pulse
    logic axi_double_reg; // uncorrectable flag pulse

    // answer one cycle after every request
    always_ff @(posedge link.clk or negedge link.reset_n) begin
        if (!link.reset_n) begin
            axi_rvalid_reg <= 1'b0;
            axi_rdata_reg <= '0;
            axi_resp_reg <= RESP_OKAY;
        end else begin
            axi_rvalid_reg <= link.axi_req;
            if (link.axi_req) begin
                // write or read of an unbacked word fails
                if (!axi_hit) begin
                    axi_rdata_reg <= '0;
                    axi_resp_reg <= RESP_SLVERR;
                end else if (link.axi_we) begin
                    // programming refused while busy
                    axi_rdata_reg <= '0;
                    axi_resp_reg <= pe_busy ? RESP_SLVERR : RESP_OKAY;
                end else if (axi_dbl) begin
                    // flag only, data left as stored
                    axi_rdata_reg <= axi_word[DATA_W-1:0];
                    axi_resp_reg <= RESP_SLVERR;
                end else begin
                    // single errors come back corrected
                    axi_rdata_reg <= axi_fixed;
                    axi_resp_reg <= RESP_OKAY;
                end
            end
        end
    end

    // error class pulses for bus reads
    always_ff @(posedge link.clk or negedge link.reset_n) begin
        if (!link.reset_n) begin
            axi_single_reg <= 1'b0;
            axi_double_reg <= 1'b0;
        end else begin
            axi_single_reg <= link.axi_req && !link.axi_we && axi_hit
                && axi_sgl;
            axi_double_reg <= link.axi_req && !link.axi_we && axi_hit
                && axi_dbl;
        end
    end

    // ------------------------------------------------------------
    // tightly coupled port answer
    // ------------------------------------------------------------
    logic tcm_rvalid_reg; // answer pulse
    logic [DATA_W-1:0] tcm_rdata_reg; // raw data
    logic [CHK_W-1:0] tcm_rcheck_reg; // raw check bits
    logic tcm_err_reg; // external error
    logic tcm_err_next; // error for this request

    // any error condition raises the external error
    always_comb begin
        tcm_err_next = 1'b0;
        // array is read-only here, write-backs included
        if (link.tcm_we) begin
            tcm_err_next = 1'b1;
        end
        // hole between the array end and the space end
        if (!tcm_hit) begin
            tcm_err_next = 1'b1;
        end
        // array busy with program or erase
        if (pe_busy) begin
            tcm_err_next = 1'b1;
        end
    end

    // answer one cycle after every request, no correction here
    always_ff @(posedge link.clk or negedge link.reset_n) begin
        if (!link.reset_n) begin
            tcm_rvalid_reg <= 1'b0;
            tcm_rdata_reg <= '0;
            tcm_rcheck_reg <= '0;
            tcm_err_reg <= 1'b0;
        end else begin
            tcm_rvalid_reg <= link.tcm_req;
            tcm_err_reg <= link.tcm_req && tcm_err_next;
            // writes answer too, with the raw word at their address
            if (link.tcm_req) begin
                tcm_rdata_reg <= tcm_word[DATA_W-1:0];
                tcm_rcheck_reg <= tcm_word[CW_W-1:DATA_W];
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign link.axi_rvalid = axi_rvalid_reg;
    assign link.axi_rdata = axi_rdata_reg;
    assign link.axi_resp = axi_resp_reg;
    assign link.tcm_rvalid = tcm_rvalid_reg;
    assign link.tcm_rdata = tcm_rdata_reg;
    assign link.tcm_rcheck = tcm_rcheck_reg;
    assign link.tcm_ext_err = tcm_err_reg;
    assign axi_single = axi_single_reg;
    assign axi_double = axi_double_reg;

endmodule : fst_flash_if

// File: core/fst_cpu_end.sv
/*
 * processor end: masters both ports, checks ecc on the coupled
 * port, writes corrected data back and takes aborts.
 * assumes the flash interface on the other side of fst_link_if and
 * user commands from logic on the same clock.
 */
`timescale 1ns/100ps
module fst_cpu_end
    import fst_pkg::*;
(
    fst_link_if.cpu link, // link to the flash interface
    input wire logic ext_err_enable, // honour external error
    input wire logic check_enable, // ecc check on coupled port
    input wire logic correct_enable, // correct-and-write-back on
    input wire logic cmd_valid, // command strobe
    input wire logic cmd_tcm, // 1 coupled port, 0 bus port
    input wire logic cmd_we, // write command
    input wire logic [ADDR_W-1:0] cmd_addr, // word address
    input wire logic [DATA_W-1:0] cmd_wdata, // write data
    output logic cmd_ready, // command can be taken
    output logic res_valid, // result pulse
    output logic [DATA_W-1:0] res_data, // read result
    output logic res_abort, // abort taken
    output logic res_slverr, // bus answered error
    output logic res_fixed // result was corrected
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00, // waiting for a command
        ST_WAIT = 2'b01, // waiting for an answer
        ST_WBACK = 2'b10 // waiting for write-back answer
    } fst_state_t;

    fst_state_t state_reg; // current state
    logic we_reg; // command was a write
    logic axi_req_reg, tcm_req_reg; // request pulses
    logic axi_we_reg, tcm_we_reg; // request write flags
    logic [ADDR_W-1:0] addr_reg; // request address
    logic [DATA_W-1:0] wdata_reg; // request write data
    logic [DATA_W-1:0] fixed_reg; // corrected data held
    logic ready_reg, rv_reg, abort_reg, slv_reg, fix_reg; // results
    logic [DATA_W-1:0] rdata_reg; // result data
    logic [DATA_W-1:0] dec_fixed; // decoder output
    logic dec_sgl, dec_dbl; // decoder classes
    logic ext; // external error that counts

    // syndrome check of raw coupled-port data
    fst_secded_dec u_tcm_dec (
        .data(link.tcm_rdata),
        .check(link.tcm_rcheck),
        .data_fixed(dec_fixed),
        .err_single(dec_sgl),
        .err_double(dec_dbl)
    );

    // disabled external error is ignored entirely
    assign ext = link.tcm_ext_err && ext_err_enable;

    // ------------------------------------------------------------
    // command and answer sequencing
    // ------------------------------------------------------------
    always_ff @(posedge link.clk or negedge link.reset_n) begin
        if (!link.reset_n) begin
            state_reg <= ST_IDLE;
            we_reg <= 1'b0;
            axi_req_reg <= 1'b0;
            tcm_req_reg <= 1'b0;
            axi_we_reg <= 1'b0;
            tcm_we_reg <= 1'b0;
            addr_reg <= '0;
            wdata_reg <= '0;
            fixed_reg <= '0;
            ready_reg <= 1'b1;
            rv_reg <= 1'b0;
            rdata_reg <= '0;
            abort_reg <= 1'b0;
            slv_reg <= 1'b0;
            fix_reg <= 1'b0;
        end else begin
            axi_req_reg <= 1'b0;
            tcm_req_reg <= 1'b0;
            rv_reg <= 1'b0;
            unique case (state_reg)
                ST_IDLE: begin
                    // issue the command on its port
                    if (cmd_valid) begin
                        axi_req_reg <= !cmd_tcm;
                        tcm_req_reg <= cmd_tcm;
                        axi_we_reg <= cmd_we;
                        tcm_we_reg <= cmd_we;
                        addr_reg <= cmd_addr;
                        wdata_reg <= cmd_wdata;
                        we_reg <= cmd_we;
                        ready_reg <= 1'b0;
                        state_reg <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (link.axi_rvalid) begin
                        // bus error answer is reported as slverr
                        rv_reg <= 1'b1;
                        rdata_reg <= link.axi_rdata;
                        slv_reg <= link.axi_resp == RESP_SLVERR;
                        abort_reg <= 1'b0;
                        fix_reg <= 1'b0;
                        ready_reg <= 1'b1;
                        state_reg <= ST_IDLE;
                    end else if (link.tcm_rvalid) begin
                        slv_reg <= 1'b0;
                        fix_reg <= 1'b0;
                        abort_reg <= 1'b0;
                        rdata_reg <= link.tcm_rdata;
                        if (!we_reg && !ext && check_enable && dec_sgl
                            && correct_enable) begin
                            // write the corrected word back first
                            tcm_req_reg <= 1'b1;
                            tcm_we_reg <= 1'b1;
                            wdata_reg <= dec_fixed;
                            fixed_reg <= dec_fixed;
                            state_reg <= ST_WBACK;
                        end else begin
                            rv_reg <= 1'b1;
                            ready_reg <= 1'b1;
                            state_reg <= ST_IDLE;
                            if (ext) begin
                                abort_reg <= 1'b1;
                            end else if (!we_reg && check_enable
                                && (dec_dbl || dec_sgl)) begin
                                // uncorrected single or double aborts
                                abort_reg <= 1'b1;
                            end
                        end
                    end
                end
                ST_WBACK: begin
                    if (link.tcm_rvalid) begin
                        // failed write-back aborts only if enabled
                        rv_reg <= 1'b1;
                        rdata_reg <= fixed_reg;
                        fix_reg <= 1'b1;
                        abort_reg <= ext;
                        ready_reg <= 1'b1;
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                    ready_reg <= 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign link.axi_req = axi_req_reg;
    assign link.axi_we = axi_we_reg;
    assign link.axi_addr = addr_reg;
    assign link.axi_wdata = wdata_reg;
    assign link.tcm_req = tcm_req_reg;
    assign link.tcm_we = tcm_we_reg;
    assign link.tcm_addr = addr_reg;
    assign link.tcm_wdata = wdata_reg;
    assign cmd_ready = ready_reg;
    assign res_valid = rv_reg;
    assign res_data = rdata_reg;
    assign res_abort = abort_reg;
    assign res_slverr = slv_reg;
    assign res_fixed = fix_reg;

endmodule : fst_cpu_end

// File: bench/fst_link_checker.sv
/*
 * assertions and covers on the flash ecc link signals.
 * assumes the bench top wires it beside fst_link_if.
 */
`timescale 1ns/100ps
module fst_link_checker
    import fst_pkg::*;
(
    input wire logic clk, // clock
    input wire logic reset_n, // reset, low
    input wire logic axi_req, // bus req
    input wire logic axi_we, // bus write
    input wire logic [ADDR_W-1:0] axi_addr, // bus addr
    input wire logic [DATA_W-1:0] axi_wdata, // bus wdata
    input wire logic axi_rvalid, // bus answer
    input wire logic [DATA_W-1:0] axi_rdata, // bus rdata
    input wire logic [1:0] axi_resp, // bus code
    input wire logic tcm_req, // tcm req
    input wire logic tcm_we, // tcm write
    input wire logic [ADDR_W-1:0] tcm_addr, // tcm addr
    input wire logic tcm_rvalid, // tcm answer
    input wire logic [DATA_W-1:0] tcm_rdata, // raw data
    input wire logic [CHK_W-1:0] tcm_rcheck, // raw check
    input wire logic tcm_ext_err // ext error
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // ----------------------------------------
    // stored word comes back on either port
    // ----------------------------------------
    property wr_rd_p;
        logic [DATA_W-1:0] wd;
        logic [ADDR_W-1:0] ad;
        (axi_req && axi_we, wd = axi_wdata, ad = axi_addr) ##1
        axi_resp == RESP_OKAY ##[2:5] (axi_req && !axi_we &&
        axi_addr == ad) |=> axi_rdata == wd;
    endproperty
    property tcm_raw_p;
        logic [DATA_W-1:0] wd;
        logic [ADDR_W-1:0] ad;
        (axi_req && axi_we, wd = axi_wdata, ad = axi_addr) ##1
        axi_resp == RESP_OKAY ##[2:5] (tcm_req && !tcm_we &&
        tcm_addr == ad) |=> tcm_rdata == wd &&
        ^{tcm_rdata, tcm_rcheck} == 1'b0;
    endproperty
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    axi_answer_a: assert property (axi_req |=> axi_rvalid)
        else $error("bus answer missing");
    axi_reserved_a: assert property (axi_req && axi_addr > FLASH_LAST
        |=> axi_resp == RESP_SLVERR && axi_rdata == '0)
        else $error("bus reserved access not refused");
    write_read_a: assert property (wr_rd_p)
        else $error("bus read differs from written word");
    resp_hold_a: assert property (!axi_rvalid |-> $stable(axi_resp))
        else $error("bus code changed without answer");
    tcm_write_err_a: assert property (tcm_req && tcm_we
        |=> tcm_rvalid && tcm_ext_err)
        else $error("coupled write not flagged");
    tcm_reserved_a: assert property (tcm_req &&
        tcm_addr > FLASH_LAST |=> tcm_ext_err)
        else $error("coupled reserved access not flagged");
    tcm_raw_a: assert property (tcm_raw_p)
        else $error("coupled read not raw word and check");
    err_pulse_a: assert property (tcm_ext_err
        |-> tcm_rvalid && $past(tcm_req))
        else $error("ext error outside an answer");
    // ----------------------------------------
    // covers
    // ----------------------------------------
    cover property (tcm_ext_err);
    cover property (axi_rvalid && axi_resp == RESP_SLVERR);
    cover property (tcm_rvalid && !tcm_ext_err);
endmodule : fst_link_checker

// File: bench/test_flash_secded_tcm_error.sv
/*
 * bench: both ends joined, driven through the command port.
 * assumes a 50 MHz clock and an async active-low reset.
 */
`timescale 1ns/100ps
module test_flash_secded_tcm_error;
    import fst_pkg::*;
    logic clk = 0, reset_n = 0, pe_busy = 0, flip_valid = 0;
    logic [ADDR_W-1:0] flip_addr = '0, cmd_addr = '0;
    logic [CW_W-1:0] flip_mask = '0;
    logic [DATA_W-1:0] cmd_wdata = '0, res_data;
    logic ee = 1, ce = 1, ke = 1, sg = 0, db = 0; // enables, flags
    logic cmd_valid = 0, cmd_tcm = 0, cmd_we = 0;
    logic axi_single, axi_double, cmd_ready, res_valid;
    logic res_abort, res_slverr, res_fixed;
    int fails = 0, checks_done = 0, cyc = 0, i;
    localparam logic [DATA_W-1:0] D1 = 64'h0123_4567_89AB_CDEF;
    localparam logic [DATA_W-1:0] D2 = 64'hFEDC_BA98_7654_3210;
    localparam logic [ADDR_W-1:0] AL = 10'h2FF, AR = 10'h300;
    localparam logic [ADDR_W-1:0] AM = 10'h010;
    always #10 clk = ~clk; // 20 ns period
    fst_link_if fst_link_if_i (.clk(clk), .reset_n(reset_n));
    fst_flash_if fst_flash_if_i (.link(fst_link_if_i.dev),
        .pe_busy(pe_busy), .flip_valid(flip_valid),
        .flip_addr(flip_addr), .flip_mask(flip_mask),
        .axi_single(axi_single), .axi_double(axi_double));
    fst_cpu_end fst_cpu_end_i (.link(fst_link_if_i.cpu),
        .ext_err_enable(ee), .check_enable(ce), .correct_enable(ke),
        .cmd_valid(cmd_valid), .cmd_tcm(cmd_tcm), .cmd_we(cmd_we),
        .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .cmd_ready(cmd_ready), .res_valid(res_valid),
        .res_data(res_data), .res_abort(res_abort),
        .res_slverr(res_slverr), .res_fixed(res_fixed));
    fst_link_checker fst_link_checker_i (.clk(clk), .reset_n(reset_n),
        .axi_req(fst_link_if_i.axi_req), .axi_we(fst_link_if_i.axi_we),
        .axi_addr(fst_link_if_i.axi_addr),
        .axi_wdata(fst_link_if_i.axi_wdata),
        .axi_rvalid(fst_link_if_i.axi_rvalid),
        .axi_rdata(fst_link_if_i.axi_rdata),
        .axi_resp(fst_link_if_i.axi_resp),
        .tcm_req(fst_link_if_i.tcm_req), .tcm_we(fst_link_if_i.tcm_we),
        .tcm_addr(fst_link_if_i.tcm_addr),
        .tcm_rvalid(fst_link_if_i.tcm_rvalid),
        .tcm_rdata(fst_link_if_i.tcm_rdata),
        .tcm_rcheck(fst_link_if_i.tcm_rcheck),
        .tcm_ext_err(fst_link_if_i.tcm_ext_err));
    // ----------------------------------------
    // sticky bus error flags, timeout
    // ----------------------------------------
    always @(negedge clk) begin
        cyc++;
        if (axi_single === 1'b1) sg = 1;
        if (axi_double === 1'b1) db = 1;
        if (cyc == 3000) begin // hang: give up
            fails++;
            end_of_test();
        end
    end
    task automatic chk(input logic [71:0] g, x);
        checks_done++;
        if (g !== x) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, g, x);
        end
    endtask : chk
    // one command; data skipped on writes and on coupled-port aborts without a fix
    task automatic op(input logic t, w, input logic [ADDR_W-1:0] a,
            input logic [DATA_W-1:0] d, input logic e, f);
        int n;
        logic [DATA_W-1:0] rd;
        sg = 0;
        db = 0;
        cmd_tcm = t; cmd_we = w; cmd_addr = a; cmd_wdata = d;
        cmd_valid = 1;
        @(negedge clk);
        cmd_valid = 0;
        n = 0;
        while (res_valid !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        rd = (w || (t && e && !f)) ? d : res_data;
        chk({n < 20, cmd_ready, rd, res_abort | res_slverr,
            t & res_fixed}, {2'b11, d, e, f});
    endtask : op
    task automatic fl(input logic [ADDR_W-1:0] a, input logic [71:0] m);
        flip_valid = 1; flip_addr = a; flip_mask = m;
        @(negedge clk);
        flip_valid = 0;
        @(negedge clk);
    endtask : fl
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_of_test
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (6) @(negedge clk);
        reset_n = 1;
        op(0, 1, AL, D1, 0, 0); op(0, 0, AL, D1, 0, 0);
        op(0, 0, AR, '0, 1, 0);
        $display("test bus done");
        for (i = 0; i < 72; i = i + 71) begin // ends of the word
            fl(AL, 72'h1 << i);
            op(0, 0, AL, D1, 0, 0); chk({sg, db}, 2'b10);
            fl(AL, 72'h1 << i);
        end
        fl(AL, 72'h40_0000_0000_0000_0001);
        op(0, 0, AL, D1 ^ 64'h1, 1, 0); chk({sg, db}, 2'b01);
        fl(AL, 72'h40_0000_0000_0000_0001);
        $display("test ecc done");
        op(0, 1, AM, D2, 0, 0); op(1, 0, AM, D2, 0, 0);
        op(1, 1, AM, D1, 1, 0); op(1, 0, AR, '0, 1, 0);
        pe_busy = 1;
        op(1, 0, AM, D2, 1, 0); op(0, 1, AM, D1, 1, 0);
        pe_busy = 0;
        op(0, 0, AM, D2, 0, 0);
        fl(AM, 72'h20);
        op(1, 0, AM, D2, 1, 1);
        ee = 0;
        op(1, 0, AM, D2, 0, 1);
        ke = 0;
        op(1, 0, AM, D2, 1, 0);
        ce = 0;
        op(1, 0, AM, D2 ^ 64'h20, 0, 0);
        $display("test coupled done");
        end_of_test();
    end
endmodule : test_flash_secded_tcm_error
